// ==== logic/srd_ctrl_top.sv ====
// Purpose: set-point ramp, dwell timer, source routing, power limits, link setup
// Assumes: all inputs synchronous to clk_sys; APB slave with no wait states
// Notes:   serial framing, control algorithm and filtering live elsewhere
`timescale 1ns/100ps
module srd_ctrl_top import srd_pkg::*; #(
  parameter int TICK_CYCLES = BASE_TICK_CYC
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // measured inputs and panel
  input  srd_val_t          in1_val,
  input  srd_val_t          in2_val,
  input  wire logic         key_up,
  input  wire logic         key_down,
  input  wire logic         event_in,
  input  wire logic         alarm1_cond,
  input  wire logic         alarm2_cond,
  // output power
  input  wire logic [6:0]   mv1_in,
  input  wire logic [6:0]   mv2_in,
  input  wire logic         mv_bypass,
  output logic [6:0]        mv1_out,
  output logic [6:0]        mv2_out,
  // alarms, display and link setup
  output logic              alarm1_out,
  output logic              alarm2_out,
  output srd_val_t          disp_value,
  output srd_val_t          pv_out,
  output srd_val_t          wsp_out,
  output srd_comm_s         comm_cfg
);
  srd_ctrl_s   ctrl_reg;
  srd_limit_s  limit_reg;
  srd_comm_s   comm_reg;
  srd_val_t    sp_reg;
  logic [15:0] ramp_reg;
  logic [15:0] dwell_reg;
  logic [3:0]  err_reg;
  srd_val_t    ramp_val_reg;
  logic        load_reg;
  logic        show_sp_reg;
  logic [15:0] div_reg;
  logic [22:0] acc_reg;
  logic [12:0] tenth_reg;
  logic        tenth_tick;
  logic        base_tick;
  logic        alm1_reg;
  logic        alm2_reg;
  logic        wr;
  logic        rd_setup;
  srd_val_t    in2_eff;
  srd_val_t    pv;
  srd_val_t    target;
  srd_val_t    ramp_nxt;
  logic        ramp_mode;
  logic        ramp_step;
  logic        ramping;
  logic        ev_eff;
  logic        rst_a1;
  logic        rst_a2;
  logic        dwell_en;
  logic        dwell_done;
  logic [22:0] per;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic known(input logic [7:0] a);
    known = a == REG_CTRL || a == REG_SP || a == REG_RAMP || a == REG_DWELL ||
            a == REG_LIMIT || a == REG_COMM || a == REG_STAT || a == REG_PV ||
            a == REG_WSP;
  endfunction

  function automatic logic [6:0] clamp(input logic [6:0] v, input logic [6:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb register file, zero wait states

  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !known(paddr);

  // configuration writes; unknown or read-only offsets are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg  <= CTRL_RST;
      limit_reg <= LIMIT_RST;
      comm_reg  <= COMM_RST;
      sp_reg    <= 16'sh0000;
      ramp_reg  <= 16'h0000;
      dwell_reg <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        REG_CTRL:  ctrl_reg  <= pwdata[19:0];
        REG_SP:    sp_reg    <= pwdata[15:0];
        REG_RAMP:  ramp_reg  <= pwdata[15:0];
        REG_DWELL: dwell_reg <= pwdata[15:0];
        REG_LIMIT: limit_reg <= pwdata[15:0];
        REG_COMM:  comm_reg  <= pwdata[14:0];
        default:   ;
      endcase
    end
  end

  // read data is captured in the setup cycle, valid in the access cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        REG_CTRL:  prdata <= {12'h000, ctrl_reg};
        REG_SP:    prdata <= {16'h0000, sp_reg};
        REG_RAMP:  prdata <= {16'h0000, ramp_reg};
        REG_DWELL: prdata <= {16'h0000, dwell_reg};
        REG_LIMIT: prdata <= {16'h0000, limit_reg};
        REG_COMM:  prdata <= {17'h00000, comm_reg};
        REG_STAT:  prdata <= {22'h000000, limit_reg.onoff, limit_reg.onoff || !limit_reg.out2_cool,
                              alarm2_out, alarm1_out, ramping, show_sp_reg, err_reg};
        REG_PV:    prdata <= {16'h0000, pv_out};
        REG_WSP:   prdata <= {16'h0000, wsp_out};
        default:   prdata <= 32'h00000000;
      endcase
    end
  end

  // out-of-range slave addresses are pinned to the legal limit
  always_comb begin
    comm_cfg = comm_reg;
    if (comm_reg.addr == 8'h00) begin
      comm_cfg.addr = 8'h01;
    end else if (comm_reg.addr > ADDR_MAX) begin
      comm_cfg.addr = ADDR_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source routing and configuration checks

  // point-to-point link shares pins with input two and the event input
  assign in2_eff = ctrl_reg.comm_p2p ? 16'sh0000 : in2_val;
  assign ev_eff  = event_in && !ctrl_reg.comm_p2p;

  // process value per selection, differential forms included
  always_comb begin
    case (ctrl_reg.process_value_source_select)
      PVS_IN1: pv = in1_val;
      PVS_IN2: pv = in2_eff;
      PVS_D12: pv = in1_val - in2_eff;
      PVS_D21: pv = in2_eff - in1_val;
      default: pv = in1_val;
    endcase
  end

  // remote modes take the set point from the other input
  always_comb begin
    case (ctrl_reg.setpoint_source_select)
      SPS_REM1: target = in1_val;
      SPS_REM2: target = in2_eff;
      default:  target = sp_reg;
    endcase
  end

  // one error at a time; the dual timer case is reported first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_reg <= ERR_NONE;
    end else if (ctrl_reg.a1_timer && ctrl_reg.a2_timer) begin
      err_reg <= ERR_TIMER;
    end else if ((ctrl_reg.setpoint_source_select == SPS_REM1 && ctrl_reg.process_value_source_select == PVS_IN1) ||
                 (ctrl_reg.setpoint_source_select == SPS_REM2 && ctrl_reg.process_value_source_select == PVS_IN2)) begin
      err_reg <= ERR_SAME;
    end else if (ctrl_reg.process_value_source_select[1] && (ctrl_reg.setpoint_source_select == SPS_REM1 || ctrl_reg.setpoint_source_select == SPS_REM2)) begin
      err_reg <= ERR_DREM;
    end else if (ctrl_reg.process_value_source_select[1] && (ctrl_reg.unit1 != ctrl_reg.unit2 || ctrl_reg.dp1 != ctrl_reg.dp2)) begin
      err_reg <= ERR_UNIT;
    end else begin
      err_reg <= ERR_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base: millisecond tick, tenth-minute tick for the dwell

  always_ff @(posedge clk_sys) begin
    if (rst || div_reg == 16'(TICK_CYCLES - 1)) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  assign base_tick = div_reg == 16'(TICK_CYCLES - 1);

  always_ff @(posedge clk_sys) begin
    if (rst || (base_tick && tenth_reg == TICKS_PER_TENTH - 13'h0001)) begin
      tenth_reg <= 13'h0000;
    end else if (base_tick) begin
      tenth_reg <= tenth_reg + 13'h0001;
    end
  end
  assign tenth_tick = base_tick && tenth_reg == TICKS_PER_TENTH - 13'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // set-point ramp

  assign ramp_mode = (ctrl_reg.setpoint_source_select == SPS_PER_MINUTE_RAMP_MODE || ctrl_reg.setpoint_source_select == SPS_HRR)
                     && ramp_reg != 16'h0000;
  assign per       = (ctrl_reg.setpoint_source_select == SPS_HRR) ? TICKS_PER_HOUR : TICKS_PER_MIN;
  assign ramping   = ramp_mode && ramp_val_reg != target;

  // reload request: pending after reset and after rate or set-point writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_reg <= 1'b1;
    end else begin
      load_reg <= wr && (paddr == REG_SP || paddr == REG_RAMP);
    end
  end

  // rate accumulator: one count each time rate*ms adds up to a period
  always_ff @(posedge clk_sys) begin
    if (rst || load_reg || !ramp_mode) begin
      acc_reg <= 23'h000000;
    end else if (base_tick) begin
      acc_reg <= (acc_reg + 23'(ramp_reg) >= per) ? acc_reg + 23'(ramp_reg) - per
                                                  : acc_reg + 23'(ramp_reg);
    end
  end
  assign ramp_step = ramp_mode && base_tick && (acc_reg + 23'(ramp_reg) >= per);

  srd_ramp_step u_step (
    .cur    (ramp_val_reg),
    .target (target),
    .step   (ramp_step),
    .nxt    (ramp_nxt)
  );

  // working set point; a zero rate bypasses the ramp entirely
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ramp_val_reg <= 16'sh0000;
    end else if (!ramp_mode) begin
      ramp_val_reg <= target;
    end else if (load_reg) begin
      ramp_val_reg <= pv;
    end else begin
      ramp_val_reg <= ramp_nxt;
    end
  end
  assign wsp_out = ramp_val_reg;

  // a key touch shows the set point until the next reload
  always_ff @(posedge clk_sys) begin
    if (rst || load_reg) begin
      show_sp_reg <= 1'b0;
    end else if (key_up || key_down) begin
      show_sp_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      disp_value <= 16'sh0000;
      pv_out     <= 16'sh0000;
    end else begin
      disp_value <= (ramping && !show_sp_reg && !key_up && !key_down) ? ramp_val_reg : target;
      pv_out     <= pv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarms and dwell timer

  assign rst_a1   = ev_eff && (ctrl_reg.event_input_function == EI_RS_A1 || ctrl_reg.event_input_function == EI_RS_A12);
  assign rst_a2   = ev_eff && (ctrl_reg.event_input_function == EI_RS_A2 || ctrl_reg.event_input_function == EI_RS_A12);
  assign dwell_en = ctrl_reg.a1_timer ^ ctrl_reg.a2_timer;

  srd_dwell_timer u_dwell (
    .clk_sys (clk_sys),
    .rst     (rst),
    .enable  (dwell_en),
    .clear   (ctrl_reg.a1_timer ? rst_a1 : rst_a2),
    .tick    (tenth_tick),
    .pv      (pv),
    .sp      (ramp_val_reg),
    .limit   (dwell_reg),
    .expired (dwell_done)
  );

  // comparator alarms are held off while the reset event stands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alm1_reg <= 1'b0;
      alm2_reg <= 1'b0;
    end else begin
      alm1_reg <= alarm1_cond && !rst_a1;
      alm2_reg <= alarm2_cond && !rst_a2;
    end
  end

  assign alarm1_out = (dwell_en && ctrl_reg.a1_timer) ? dwell_done : alm1_reg;
  assign alarm2_out = (dwell_en && ctrl_reg.a2_timer) ? dwell_done : alm2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output power limits

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mv1_out <= 7'h00;
      mv2_out <= 7'h00;
    end else if (mv_bypass || limit_reg.onoff) begin
      mv1_out <= mv1_in;
      mv2_out <= mv2_in;
    end else begin
      mv1_out <= clamp(mv1_in, limit_reg.pl1);
      mv2_out <= limit_reg.out2_cool ? clamp(mv2_in, limit_reg.pl2) : mv2_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_zero_rate;
    @(posedge clk_sys) disable iff (rst) ramp_reg == 16'h0000 |=> wsp_out == $past(target);
  endproperty
  a_zero_rate: assert property (p_zero_rate) else $error("zero rate did not bypass ramp");

  property p_load;
    @(posedge clk_sys) disable iff (rst) load_reg && ramp_mode |=> wsp_out == $past(pv);
  endproperty
  a_load: assert property (p_load) else $error("ramp value not loaded with pv");

  property p_step;
    @(posedge clk_sys) disable iff (rst) ramp_mode && !load_reg && $stable(target) && ramp_mode
      |=> (wsp_out - $past(wsp_out) <= 16'sh0001) && ($past(wsp_out) - wsp_out <= 16'sh0001);
  endproperty
  a_step: assert property (p_step) else $error("ramp moved more than one count");

  property p_dual;
    @(posedge clk_sys) disable iff (rst) ctrl_reg.a1_timer && ctrl_reg.a2_timer |=> err_reg == ERR_TIMER;
  endproperty
  a_dual: assert property (p_dual) else $error("dual timer not flagged");

  property p_same;
    @(posedge clk_sys) disable iff (rst) !(ctrl_reg.a1_timer && ctrl_reg.a2_timer)
      && ctrl_reg.setpoint_source_select == SPS_REM2 && ctrl_reg.process_value_source_select == PVS_IN2 |=> err_reg == ERR_SAME;
  endproperty
  a_same: assert property (p_same) else $error("same source not flagged");

  property p_unit;
    @(posedge clk_sys) disable iff (rst) !(ctrl_reg.a1_timer && ctrl_reg.a2_timer) && ctrl_reg.process_value_source_select[1]
      && ctrl_reg.setpoint_source_select == SPS_LOCAL && (ctrl_reg.unit1 != ctrl_reg.unit2 || ctrl_reg.dp1 != ctrl_reg.dp2)
      |=> err_reg == ERR_UNIT;
  endproperty
  a_unit: assert property (p_unit) else $error("unit mismatch not flagged");

  property p_limit;
    @(posedge clk_sys) disable iff (rst) !mv_bypass && !limit_reg.onoff |=> mv1_out <= $past(limit_reg.pl1);
  endproperty
  a_limit: assert property (p_limit) else $error("heat output above limit");

  property p_bypass;
    @(posedge clk_sys) disable iff (rst) mv_bypass |=> mv1_out == $past(mv1_in) && mv2_out == $past(mv2_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("manual output was clamped");

  property p_p2p;
    @(posedge clk_sys) disable iff (rst) ctrl_reg.comm_p2p && ctrl_reg.process_value_source_select == PVS_IN2 |=> pv_out == 16'sh0000;
  endproperty
  a_p2p: assert property (p_p2p) else $error("input two not disconnected");

  property p_key;
    @(posedge clk_sys) disable iff (rst) key_up |=> disp_value == $past(target);
  endproperty
  a_key: assert property (p_key) else $error("key did not show set point");

  c_ramp:  cover property (@(posedge clk_sys) disable iff (rst) ramp_step ##1 ramping);
  c_dwell: cover property (@(posedge clk_sys) disable iff (rst) $rose(dwell_done));
  c_reset: cover property (@(posedge clk_sys) disable iff (rst) rst_a1 && alarm1_cond);
endmodule

// ==== pkg/srd_pkg.sv ====
// Purpose: shared constants and types of the set-point ramp and dwell controller
// Assumes: 40 MHz system clock, APB register access
// Notes:   process values are signed 16-bit engineering counts
package srd_pkg;
  typedef logic signed [15:0] srd_val_t;
  // clock and time base
  localparam int CLK_HZ         = 40_000_000;
  localparam int BASE_TICK_US   = 1000;
  localparam int BASE_TICK_CYC  = CLK_HZ / 1_000_000 * BASE_TICK_US;
  localparam int MIN_MS         = 60_000;
  localparam int HOUR_MS        = 3_600_000;
  localparam int TENTH_MIN_MS   = 6_000;
  localparam logic [22:0] TICKS_PER_MIN  = 23'(MIN_MS * 1000 / BASE_TICK_US);
  // divide first: the hour in microseconds does not fit a 32-bit int
  localparam logic [22:0] TICKS_PER_HOUR = 23'(HOUR_MS / BASE_TICK_US * 1000);
  localparam logic [12:0] TICKS_PER_TENTH = 13'(TENTH_MIN_MS * 1000 / BASE_TICK_US);
  // register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_SP    = 8'h04;
  localparam logic [7:0] REG_RAMP  = 8'h08;
  localparam logic [7:0] REG_DWELL = 8'h0c;
  localparam logic [7:0] REG_LIMIT = 8'h10;
  localparam logic [7:0] REG_COMM  = 8'h14;
  localparam logic [7:0] REG_STAT  = 8'h18;
  localparam logic [7:0] REG_PV    = 8'h1c;
  localparam logic [7:0] REG_WSP   = 8'h20;
  // set-point and process-value sources
  localparam logic [2:0] SPS_LOCAL = 3'h0;
  localparam logic [2:0] SPS_PER_MINUTE_RAMP_MODE  = 3'h1;
  localparam logic [2:0] SPS_HRR   = 3'h2;
  localparam logic [2:0] SPS_REM1  = 3'h3;
  localparam logic [2:0] SPS_REM2  = 3'h4;
  localparam logic [1:0] PVS_IN1   = 2'h0;
  localparam logic [1:0] PVS_IN2   = 2'h1;
  localparam logic [1:0] PVS_D12   = 2'h2;
  localparam logic [1:0] PVS_D21   = 2'h3;
  // event input functions that reset alarms
  localparam logic [3:0] EI_RS_A1  = 4'h4;
  localparam logic [3:0] EI_RS_A2  = 4'h5;
  localparam logic [3:0] EI_RS_A12 = 4'h6;
  // configuration error codes
  localparam logic [3:0] ERR_NONE  = 4'h0;
  localparam logic [3:0] ERR_SAME  = 4'h2;
  localparam logic [3:0] ERR_DREM  = 4'h3;
  localparam logic [3:0] ERR_TIMER = 4'h4;
  localparam logic [3:0] ERR_UNIT  = 4'h5;
  // packed register layouts
  typedef struct packed {
    logic [1:0] dp2;
    logic [1:0] dp1;
    logic [1:0] unit2;
    logic [1:0] unit1;
    logic [3:0] event_input_function;
    logic       comm_p2p;
    logic       a2_timer;
    logic       a1_timer;
    logic [1:0] process_value_source_select;
    logic [2:0] setpoint_source_select;
  } srd_ctrl_s;
  typedef struct packed {
    logic       onoff;
    logic       out2_cool;
    logic [6:0] pl2;
    logic [6:0] pl1;
  } srd_limit_s;
  typedef struct packed {
    logic       stop2;
    logic [1:0] parity;
    logic       data8;
    logic [2:0] baud;
    logic [7:0] addr;
  } srd_comm_s;
  localparam srd_ctrl_s  CTRL_RST  = 20'h00000;
  localparam srd_limit_s LIMIT_RST = 16'h3264;
  localparam srd_comm_s  COMM_RST  = 15'h1101;
  localparam logic [7:0] ADDR_MAX  = 8'hf7;
endpackage

// ==== logic/srd_ramp_step.sv ====
// Purpose: one-count move of the ramping value toward its target
// Assumes: called at most once per ramp step
// Notes:   never passes the target
`timescale 1ns/100ps
module srd_ramp_step import srd_pkg::*; (
  // values
  input  srd_val_t   cur,
  input  srd_val_t   target,
  input  wire logic  step,
  // result
  output srd_val_t   nxt
);
  // unit move lands exactly on target, so no overshoot is possible
  always_comb begin
    if (!step || cur == target) begin
      nxt = cur;
    end else if (cur < target) begin
      nxt = cur + 16'sh0001;
    end else begin
      nxt = cur - 16'sh0001;
    end
  end
endmodule

// ==== logic/srd_dwell_timer.sv ====
// Purpose: dwell timer carried by an alarm channel
// Assumes: tick is a one-cycle pulse every tenth of a minute
// Notes:   limit is read live, so edits act on the running count
`timescale 1ns/100ps
module srd_dwell_timer import srd_pkg::*; (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // control
  input  wire logic         enable,
  input  wire logic         clear,
  input  wire logic         tick,
  input  srd_val_t          pv,
  input  srd_val_t          sp,
  input  wire logic [15:0]  limit,
  // status
  output logic              expired
);
  logic        above_reg;
  logic        seen_reg;
  logic        run_reg;
  logic [15:0] cnt_reg;
  logic        reach;

  // reached on equality or on the pv crossing the set point
  assign reach = (pv == sp) || (seen_reg && above_reg != (pv >= sp));

  always_ff @(posedge clk_sys) begin
    if (rst || !enable || clear) begin
      seen_reg  <= 1'b0;
      above_reg <= 1'b0;
    end else begin
      seen_reg  <= 1'b1;
      above_reg <= pv >= sp;
    end
  end

  // count starts once and keeps running while the set point moves
  always_ff @(posedge clk_sys) begin
    if (rst || !enable || clear) begin
      run_reg <= 1'b0;
      cnt_reg <= 16'h0000;
    end else begin
      if (reach) begin
        run_reg <= 1'b1;
      end
      if (run_reg && tick && cnt_reg < limit) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // latched until cleared; a shortened limit expires at once
  always_ff @(posedge clk_sys) begin
    if (rst || !enable || clear) begin
      expired <= 1'b0;
    end else if (run_reg && cnt_reg >= limit) begin
      expired <= 1'b1;
    end
  end
endmodule

// ==== testbench/srd_host_model.sv ====
// Purpose: host end of the multidrop link
// Assumes: host framing copies the unit's own settings
// Notes:   sel is high when the addressed unit answers
`timescale 1ns/100ps
module srd_host_model import srd_pkg::*; (
  // link setup
  input  srd_comm_s        cfg,
  input  wire logic [7:0]  target,
  // result
  output logic             sel
);
  // one unit per address in 1..247, same framing as cfg
  assign sel = (cfg.addr == target) && (target != 8'h00) && (target <= ADDR_MAX);
endmodule

// ==== testbench/setpoint_ramp_dwell_control_tb.sv ====
// Purpose: self-checking bench of the set-point controller
// Assumes: TICK_CYCLES shortened to 4, so a tenth minute is 24000 clocks
// Notes:   apb master waits on pready, no fixed latency assumed
`timescale 1ns/100ps
module setpoint_ramp_dwell_control_tb import srd_pkg::*;;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, se, hsel;
  logic        key_up, key_down, event_in, alarm1_cond, alarm2_cond, mv_bypass, alarm1_out, alarm2_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  mv1_in, mv2_in, mv1_out, mv2_out;
  srd_val_t    in1_val, in2_val, disp_value, pv_out, wsp_out;
  srd_comm_s   comm_cfg;
  srd_limit_s  l;
  int          n_mismatch, n_tests, cyc;
  logic [2:0]  ts [6] = '{SPS_LOCAL, SPS_REM1, SPS_REM2, SPS_REM1, SPS_LOCAL, SPS_REM1};
  logic [1:0]  tp [6] = '{PVS_IN1, PVS_IN1, PVS_IN2, PVS_D12, PVS_D21, PVS_IN2};
  logic [3:0]  te [6] = '{ERR_TIMER, ERR_SAME, ERR_SAME, ERR_DREM, ERR_UNIT, ERR_NONE};
  srd_ctrl_top #(.TICK_CYCLES(4)) DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in1_val, .in2_val, .key_up, .key_down, .event_in, .alarm1_cond, .alarm2_cond,
    .mv1_in, .mv2_in, .mv_bypass, .mv1_out, .mv2_out, .alarm1_out, .alarm2_out, .disp_value, .pv_out,
    .wsp_out, .comm_cfg);
  srd_host_model host (.cfg(comm_cfg), .target(8'h07), .sel(hsel));
  ////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling so a hang still reaches the verdict
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // request held until pready is sampled high, then released
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] cw(logic [2:0] s, logic [1:0] p, logic t1, logic [3:0] e, logic u, logic q);
    srd_ctrl_s k;
    k = '0;
    k.setpoint_source_select = s;
    k.process_value_source_select = p;
    k.a1_timer = t1;
    k.a2_timer = t1 & (s == SPS_LOCAL) & (p == PVS_IN1) & (e == 4'h0);
    k.event_input_function = e;
    k.unit2 = {1'b0, u};
    k.comm_p2p = q;
    return 32'(k);
  endfunction
  // bypass and on-off leave the demand untouched
  function automatic logic [6:0] lim(logic [6:0] mv, logic [6:0] pl, logic byp);
    return (byp || mv <= pl) ? mv : pl;
  endfunction
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, key_up, key_down, event_in, alarm1_cond, alarm2_cond} = '0;
    {mv_bypass, mv1_in, mv2_in, in2_val, n_mismatch, n_tests, cyc} = '0;
    in1_val = 16'sh0064;
    rst = 1'b1;
    void'($urandom(45266));
    wt(2);
    rst <= 1'b0;
    apb(0, REG_LIMIT, 0);
    chk("limit_rst", 32'h3264, rd);
    apb(0, REG_COMM, 0);
    chk("comm_rst", 32'h1101, rd);
    apb(0, 8'h40, 0);
    chk("unmapped_err", 32'h1, {31'h0, se});
    $display("test reset done");
    in1_val <= 16'($urandom_range(8000));
    in2_val <= 16'($urandom_range(8000));
    for (int i = 0; i < 6; i++) begin
      apb(1, REG_CTRL, cw(ts[i], tp[i], i == 0, 4'h0, i == 4, 1'b0));
      apb(0, REG_STAT, 0);
      chk("cfg_err", 32'(te[i]), 32'(rd[3:0]));
    end
    wt(3);
    chk("pv_remote", in2_val, pv_out);
    chk("wsp_remote", in1_val, wsp_out);
    apb(1, REG_CTRL, cw(SPS_LOCAL, PVS_D12, 0, 4'h0, 0, 0));
    wt(3);
    chk("pv_d12", in1_val - in2_val, pv_out);
    apb(1, REG_CTRL, cw(SPS_LOCAL, PVS_D21, 0, 4'h0, 0, 0));
    wt(3);
    chk("pv_d21", in2_val - in1_val, pv_out);
    $display("test routing done");
    for (int i = 0; i < 8; i++) begin
      l = '0;
      l.pl1 = (i == 1) ? 7'h00 : 7'($urandom_range(100));
      l.pl2 = 7'($urandom_range(100));
      l.out2_cool = 1'b1;
      l.onoff = (i == 7);
      mv_bypass <= (i == 6);
      mv1_in <= 7'($urandom_range(100));
      mv2_in <= 7'($urandom_range(100));
      apb(1, REG_LIMIT, 32'(l));
      wt(3);
      chk("mv1", lim(mv1_in, l.pl1, l.onoff | mv_bypass), mv1_out);
      chk("mv2", lim(mv2_in, l.pl2, l.onoff | mv_bypass), mv2_out);
    end
    l.out2_cool = 1'b0;
    apb(1, REG_LIMIT, 32'(l));
    apb(0, REG_STAT, 0);
    chk("hidden", 32'h3, 32'(rd[9:8]));
    $display("test limits done");
    apb(1, REG_COMM, 32'h0);
    wt(1);
    chk("addr_low", 32'h1, 32'(comm_cfg.addr));
    apb(1, REG_COMM, 32'hfa);
    wt(1);
    chk("addr_high", 32'(ADDR_MAX), 32'(comm_cfg.addr));
    apb(1, REG_COMM, 32'h0b07);
    wt(2);
    chk("link_cfg", 32'h0b07, 32'(comm_cfg));
    chk("host_sel", 32'h1, 32'(hsel));
    $display("test link done");
    in1_val <= 16'sh0064;
    apb(1, REG_CTRL, cw(SPS_PER_MINUTE_RAMP_MODE, PVS_IN1, 0, 4'h0, 0, 0));
    apb(1, REG_RAMP, 32'd60000);
    apb(1, REG_SP, 32'h6e);
    wt(10);
    chk("ramp_mid", 32'h1, 32'(wsp_out >= 100 && wsp_out < 108));
    key_up <= 1'b1;
    wt(3);
    chk("disp_sp", 32'h6e, 32'(disp_value));
    key_up <= 1'b0;
    wt(100);
    chk("ramp_end", 32'h6e, 32'(wsp_out));
    apb(1, REG_CTRL, cw(SPS_HRR, PVS_IN1, 0, 4'h0, 0, 0));
    apb(1, REG_SP, 32'h78);
    wt(100);
    chk("ramp_hour", 32'h1, 32'(wsp_out >= 100 && wsp_out < 102));
    apb(1, REG_RAMP, 32'h0);
    apb(1, REG_SP, 32'h82);
    wt(3);
    chk("ramp_off", 32'h82, 32'(wsp_out));
    $display("test ramp done");
    in1_val <= 16'sh0032;
    apb(1, REG_CTRL, cw(SPS_LOCAL, PVS_IN1, 1, EI_RS_A1, 0, 0));
    apb(1, REG_DWELL, 32'h2);
    apb(1, REG_SP, 32'h32);
    wt(20000);
    chk("dwell_early", 32'h0, 32'(alarm1_out));
    apb(1, REG_DWELL, 32'h1);
    wt(6000);
    chk("dwell_done", 32'h1, 32'(alarm1_out));
    in1_val <= 16'sh0000;
    wt(5);
    chk("dwell_latch", 32'h1, 32'(alarm1_out));
    event_in <= 1'b1;
    wt(3);
    chk("dwell_clear", 32'h0, 32'(alarm1_out));
    event_in <= 1'b0;
    apb(1, REG_CTRL, cw(SPS_LOCAL, PVS_IN1, 0, EI_RS_A2, 0, 0));
    alarm2_cond <= 1'b1;
    event_in <= 1'b1;
    wt(3);
    chk("a2_reset", 32'h0, 32'(alarm2_out));
    event_in <= 1'b0;
    wt(3);
    chk("a2_retrig", 32'h1, 32'(alarm2_out));
    apb(1, REG_CTRL, cw(SPS_LOCAL, PVS_IN2, 0, EI_RS_A2, 0, 1));
    event_in <= 1'b1;
    wt(3);
    chk("p2p_event", 32'h1, 32'(alarm2_out));
    chk("p2p_pv", 32'h0, pv_out);
    $display("test alarms done");
    final_report;
  end
endmodule
